// >>> rtl/fws_host_ctrl.sv
// Host controller that polls flash write status over the parallel bus.
// Assumes the flash pins are asynchronous to clk; inputs are synchronised here.
//
// Overview of operation
// - Host reads twice, compares toggle bit
// - Toggling with timeout_flag: recheck, then reset
// - Resumed polling restarts with fresh double read
// - After timeout failure host issues reset
// - Host checks erase_window_flag around added sectors
`timescale 1ns/100ps
module fws_host_ctrl (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // User requests
   input  wire logic               req_valid,
   input  wire fws_pkg::fws_req_t  req,
   output logic                    req_ready,
   output logic                    rsp_valid,
   output fws_pkg::fws_rsp_t       rsp,
   output logic                    flash_busy,
   // Flash pins
   output fws_pkg::fws_pins_t      flash_pins,
   input  wire logic [7:0]         dq_in,
   input  wire logic               ready_busy_n
);

   typedef enum logic [3:0] {ST_IDLE, ST_READ_A, ST_READ_B, ST_DECIDE, ST_WRITE,
                             ST_PRECHECK, ST_ADD_WRITE, ST_POSTCHECK} fws_state_t;

   typedef struct packed {
      fws_state_t          st;
      fws_pkg::fws_op_t    op;
      logic [fws_pkg::ADDR_W-1:0] addr;
      logic [7:0]          first_rd;
      logic [7:0]          last_rd;
      logic                retry;
      logic                cyc_valid;
      fws_pkg::fws_cyc_t   cyc;
      logic                req_ready;
      logic                rsp_valid;
      fws_pkg::fws_rsp_t   rsp;
      logic                rb_s1;
      logic                rb_s2;
      logic                busy;
   } fws_q_t;

   fws_q_t     q;
   fws_q_t     n;
   logic       cyc_done;
   logic [7:0] rdata;

   // ==========================================================
   // Bus cycle engine
   fws_bus_cycle i_fws_bus_cycle (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .cyc_valid (q.cyc_valid),
      .cyc       (q.cyc),
      .cyc_done  (cyc_done),
      .rdata     (rdata),
      .pins      (flash_pins),
      .dq_in     (dq_in)
   );

   // ==========================================================
   // Status polling sequencer
   always_comb begin
      n           = q;
      n.cyc_valid = 1'h0;
      n.rsp_valid = 1'h0;
      n.rb_s1     = ready_busy_n;
      n.rb_s2     = q.rb_s1;
      n.busy      = !q.rb_s2;
      unique case (q.st)
         ST_IDLE: begin
            if (req_valid) begin
               n.req_ready   = 1'h0;
               n.op          = req.op;
               n.addr        = req.addr;
               n.retry       = 1'h0;
               n.rsp.code    = fws_pkg::RES_DONE;
               n.cyc_valid   = 1'h1;
               n.cyc.write   = 1'h0;
               n.cyc.addr    = req.addr;
               n.cyc.wdata   = '0;
               unique case (req.op)
                  fws_pkg::OP_POLL:       n.st = ST_READ_A;
                  fws_pkg::OP_ADD_SECTOR: n.st = ST_PRECHECK;
                  fws_pkg::OP_SUSPEND: begin
                     n.cyc.write = 1'h1;
                     n.cyc.wdata = fws_pkg::CMD_SUSPEND;
                     n.st        = ST_WRITE;
                  end
                  fws_pkg::OP_RESET: begin
                     n.cyc.write = 1'h1;
                     n.cyc.addr  = fws_pkg::RESET_ADDR;
                     n.cyc.wdata = fws_pkg::CMD_RESET;
                     n.st        = ST_WRITE;
                  end
               endcase
            end
         end
         ST_READ_A: begin
            if (cyc_done) begin
               // Second read of the pair at the same address
               n.first_rd  = rdata;
               n.cyc_valid = 1'h1;
               n.st        = ST_READ_B;
            end
         end
         ST_READ_B: begin
            if (cyc_done) begin
               n.last_rd = rdata;
               n.st      = ST_DECIDE;
            end
         end
         ST_DECIDE: begin
            if (q.first_rd[fws_pkg::BIT_TOGGLE] == q.last_rd[fws_pkg::BIT_TOGGLE]) begin
               n.rsp_valid  = 1'h1;
               n.rsp.status = q.last_rd;
               n.req_ready  = 1'h1;
               n.st         = ST_IDLE;
            end else if (q.last_rd[fws_pkg::BIT_TIMEOUT] && q.retry) begin
               // Still toggling after the recheck: recover with reset
               n.rsp.code  = fws_pkg::RES_FAIL;
               n.cyc_valid = 1'h1;
               n.cyc.write = 1'h1;
               n.cyc.addr  = fws_pkg::RESET_ADDR;
               n.cyc.wdata = fws_pkg::CMD_RESET;
               n.st        = ST_WRITE;
            end else begin
               // Every further look starts from a fresh pair of reads
               n.retry     = q.retry | q.last_rd[fws_pkg::BIT_TIMEOUT];
               n.cyc_valid = 1'h1;
               n.st        = ST_READ_A;
            end
         end
         ST_WRITE: begin
            if (cyc_done) begin
               n.rsp_valid  = 1'h1;
               n.rsp.status = q.last_rd;
               n.req_ready  = 1'h1;
               n.st         = ST_IDLE;
            end
         end
         ST_PRECHECK: begin
            if (cyc_done) begin
               n.last_rd = rdata;
               if (rdata[fws_pkg::BIT_WINDOW]) begin
                  // Window already closed: the added sector would be ignored
                  n.rsp_valid  = 1'h1;
                  n.rsp.code   = fws_pkg::RES_REFUSED;
                  n.rsp.status = rdata;
                  n.req_ready  = 1'h1;
                  n.st         = ST_IDLE;
               end else begin
                  n.cyc_valid = 1'h1;
                  n.cyc.write = 1'h1;
                  n.cyc.addr  = q.addr;
                  n.cyc.wdata = fws_pkg::CMD_SECTOR_ERASE;
                  n.st        = ST_ADD_WRITE;
               end
            end
         end
         ST_ADD_WRITE: begin
            if (cyc_done) begin
               n.cyc_valid = 1'h1;
               n.cyc.write = 1'h0;
               n.st        = ST_POSTCHECK;
            end
         end
         ST_POSTCHECK: begin
            if (cyc_done) begin
               n.last_rd    = rdata;
               n.rsp_valid  = 1'h1;
               n.rsp.status = rdata;
               n.rsp.code   = rdata[fws_pkg::BIT_WINDOW] ? fws_pkg::RES_UNSURE : fws_pkg::RES_DONE;
               n.req_ready  = 1'h1;
               n.st         = ST_IDLE;
            end
         end
         default: begin
            n.st        = ST_IDLE;
            n.req_ready = 1'h1;
         end
      endcase
      n.rsp.busy_pin = q.busy;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q           <= '0;
         q.req_ready <= 1'h1;
         q.rb_s1     <= 1'h1;
         q.rb_s2     <= 1'h1;
      end else begin
         q <= n;
      end
   end

   assign req_ready  = q.req_ready;
   assign rsp_valid  = q.rsp_valid;
   assign rsp        = q.rsp;
   assign flash_busy = q.busy;

   // ==========================================================
   // Checks
   localparam int POST_MAX = 40;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_read_a_done;
      (q.st == ST_READ_A) && cyc_done;
   endsequence

   sequence s_sector_written;
      (q.st == ST_ADD_WRITE) && cyc_done;
   endsequence

   chk_poll_done_stable:
   assert property ((q.rsp_valid && q.op == fws_pkg::OP_POLL && q.rsp.code == fws_pkg::RES_DONE)
      |-> q.first_rd[fws_pkg::BIT_TOGGLE] == q.last_rd[fws_pkg::BIT_TOGGLE])
      else $error("poll finished while toggle bit still changed");

   chk_recheck_before_reset:
   assert property ((q.cyc_valid && q.cyc.write && q.op == fws_pkg::OP_POLL)
      |-> (q.retry && q.last_rd[fws_pkg::BIT_TIMEOUT] && $past(q.st) == ST_DECIDE))
      else $error("reset issued without a second toggle check");

   chk_fresh_pair:
   assert property (s_read_a_done |=> (q.st == ST_READ_B && q.cyc_valid && !q.cyc.write))
      else $error("poll pair not read back to back");

   chk_fail_after_reset:
   assert property ((q.rsp_valid && q.rsp.code == fws_pkg::RES_FAIL)
      |-> (q.cyc.write && q.cyc.wdata == fws_pkg::CMD_RESET && $past(cyc_done)))
      else $error("failure reported without a reset command");

   chk_window_gate:
   assert property ((q.cyc_valid && q.cyc.write && q.cyc.wdata == fws_pkg::CMD_SECTOR_ERASE)
      |-> !q.last_rd[fws_pkg::BIT_WINDOW])
      else $error("sector added with the erase window closed");

   chk_window_recheck:
   assert property (s_sector_written |=> (q.cyc_valid && !q.cyc.write) ##[1:POST_MAX] q.rsp_valid)
      else $error("no status check after adding a sector");

endmodule : fws_host_ctrl

// >>> rtl/fws_pkg.sv
// Shared types and constants of the flash status-polling host controller.
// Assumes one 40 MHz clock and an 8-bit status read path from the flash.
package fws_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RD_ACCESS_NS  = 90;
   localparam int WE_PULSE_NS   = 35;
   localparam int SYNC_STAGES   = 2;
   localparam logic [3:0] RD_SAMPLE_CYC =
      4'((RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] WE_PULSE_CYC =
      4'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================
   // Widths and status bit positions
   localparam int ADDR_W      = 22;
   localparam int DATA_W      = 8;
   localparam int BIT_POLL    = 7;
   localparam int BIT_TOGGLE  = 6;
   localparam int BIT_TIMEOUT = 5;
   localparam int BIT_WINDOW  = 3;
   localparam int BIT_SECTOR  = 2;

   // ==========================================================
   // Command codes
   localparam logic [DATA_W-1:0] CMD_RESET        = 8'hF0;
   localparam logic [DATA_W-1:0] CMD_SUSPEND      = 8'hB0;
   localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [ADDR_W-1:0] RESET_ADDR       = 22'h000000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {OP_POLL, OP_ADD_SECTOR, OP_SUSPEND, OP_RESET} fws_op_t;
   typedef enum logic [1:0] {RES_DONE, RES_FAIL, RES_REFUSED, RES_UNSURE} fws_res_t;

   typedef struct packed {
      fws_op_t             op;
      logic [ADDR_W-1:0]   addr;
   } fws_req_t;

   typedef struct packed {
      fws_res_t            code;
      logic [DATA_W-1:0]   status;
      logic                busy_pin;
   } fws_rsp_t;

   typedef struct packed {
      logic                write;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } fws_cyc_t;

   typedef struct packed {
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq_out;
      logic                dq_oe;
   } fws_pins_t;

   localparam fws_pins_t PINS_IDLE = '{ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1,
                                       addr: '0, dq_out: '0, dq_oe: 1'h0};

endpackage : fws_pkg

// >>> rtl/fws_bus_cycle.sv
// Single read or write cycle on the flash parallel pins.
// Assumes a one-cycle request pulse only while the engine is idle.
`timescale 1ns/100ps
module fws_bus_cycle (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Cycle request
   input  wire logic              cyc_valid,
   input  wire fws_pkg::fws_cyc_t cyc,
   output logic                   cyc_done,
   output logic [7:0]             rdata,
   // Flash pins
   output fws_pkg::fws_pins_t     pins,
   input  wire logic [7:0]        dq_in
);

   typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} fws_bc_state_t;

   typedef struct packed {
      fws_bc_state_t       st;
      logic [3:0]          cnt;
      logic                write;
      fws_pkg::fws_pins_t  pins;
      logic [7:0]          dq_s1;
      logic [7:0]          dq_s2;
      logic [7:0]          rdata;
      logic                done;
   } fws_bc_q_t;

   fws_bc_q_t q;
   fws_bc_q_t n;

   // ==========================================================
   // Cycle sequencing
   always_comb begin
      n       = q;
      n.done  = 1'h0;
      n.dq_s1 = dq_in;
      n.dq_s2 = q.dq_s1;
      unique case (q.st)
         BC_IDLE: begin
            if (cyc_valid) begin
               n.pins.ce_n   = 1'h0;
               n.pins.addr   = cyc.addr;
               n.pins.dq_out = cyc.wdata;
               n.pins.dq_oe  = cyc.write;
               n.write       = cyc.write;
               n.st          = BC_SETUP;
            end
         end
         BC_SETUP: begin
            if (q.write) begin
               n.pins.we_n = 1'h0;
            end else begin
               n.pins.oe_n = 1'h0;
            end
            n.cnt = 4'h0;
            n.st  = BC_STROBE;
         end
         BC_STROBE: begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == ((q.write ? fws_pkg::WE_PULSE_CYC : fws_pkg::RD_SAMPLE_CYC) - 4'h1)) begin
               // Read data has passed the synchroniser by now
               n.pins.we_n = 1'h1;
               n.pins.oe_n = 1'h1;
               if (!q.write) begin
                  n.rdata = q.dq_s2;
               end
               n.st = BC_RECOVER;
            end
         end
         BC_RECOVER: begin
            // Chip select rises between cycles so every read is a fresh one
            n.pins.ce_n  = 1'h1;
            n.pins.dq_oe = 1'h0;
            n.done       = 1'h1;
            n.st         = BC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q      <= '0;
         q.pins <= fws_pkg::PINS_IDLE;
      end else begin
         q <= n;
      end
   end

   assign pins     = q.pins;
   assign cyc_done = q.done;
   assign rdata    = q.rdata;

   // ==========================================================
   // Checks
   chk_strobe_exclusive:
   assert property (@(posedge clk) disable iff (sys_rst) !(!q.pins.oe_n && !q.pins.we_n))
      else $error("output and write strobes low together");

   chk_read_strobe_width:
   assert property (@(posedge clk) disable iff (sys_rst)
      $fell(q.pins.oe_n) |-> (!q.pins.oe_n)[*6] ##1 q.pins.oe_n ##1 q.pins.ce_n)
      else $error("read strobe width wrong");

endmodule : fws_bus_cycle

// >>> testbench/fws_flash_model.sv
// Behavioural flash status source for the host controller bench.
// Assumes the bench resolves the ready line with a pull-up; the bench sets each operation up.
`timescale 1ns/100ps
module fws_flash_model (
   // Flash pins
   input  wire fws_pkg::fws_pins_t pins,
   output logic [7:0]              dq_in,
   output logic                    rb_oe
);
   int          left     = 0;
   int          adds     = 0;
   int          writes   = 0;
   logic        tog      = 1'h0;
   logic        stog     = 1'h0;
   logic        tmo      = 1'h0;
   logic        win      = 1'h0;
   logic        shut     = 1'h0;
   logic        susp     = 1'h0;
   logic [7:0]  last     = 8'h00;
   logic [7:0]  cmd      = 8'h00;
   logic [21:0] cmd_addr = 22'h000000;
   logic        busy;
   logic [7:0]  st;

   // ==========================================================
   // Operation setup
   task automatic start(input int n, input logic t, input logic w, input logic s);
      left = n;
      tmo = t;
      win = w;
      shut = s;
      susp = 1'h0;
   endtask : start

   // ==========================================================
   // Status byte and ready line
   assign busy = (left > 0) && !susp;
   assign rb_oe = busy;
   assign st = {!busy, tog, tmo, 1'h0, win, stog, 2'h0};
   // Released lanes show the inverse of the last byte
   assign dq_in = (pins.ce_n === 1'h0 && pins.oe_n === 1'h0) ? st : ~last;

   // ==========================================================
   // Read end
   always @(posedge pins.oe_n) begin
      if (pins.ce_n === 1'h0) begin
         last = st;
         if (busy) begin
            tog = ~tog;
            left--;
         end
         if (left > 0)
            stog = ~stog;
      end
   end

   // ==========================================================
   // Command writes
   always @(posedge pins.we_n) begin
      // Every write strobe is counted, accepted or not
      if (pins.ce_n === 1'h0)
         writes++;
      if (pins.ce_n === 1'h0 && (!win || pins.dq_out == fws_pkg::CMD_SUSPEND)) begin
         cmd = pins.dq_out;
         cmd_addr = pins.addr;
         case (pins.dq_out)
            fws_pkg::CMD_RESET: begin
               left = 0;
               tmo = 1'h0;
            end
            fws_pkg::CMD_SUSPEND: susp = 1'h1;
            fws_pkg::CMD_SECTOR_ERASE: begin
               adds++;
               win = shut;
            end
            default: ;
         endcase
      end
   end
endmodule : fws_flash_model

// >>> testbench/test_fws_host_ctrl.sv
// Self-checking bench of the flash status-polling host controller.
// Assumes the flash model answers on the parallel pins with a pulled-up ready line.
`timescale 1ns/100ps
module test_fws_host_ctrl;
   logic                clk          = 1'h0;
   logic                sys_rst      = 1'h1;
   logic                req_valid    = 1'h0;
   fws_pkg::fws_req_t   req          = '0;
   logic                req_ready;
   logic                rsp_valid;
   fws_pkg::fws_rsp_t   rsp;
   logic                flash_busy;
   fws_pkg::fws_pins_t  flash_pins;
   logic [7:0]          dq_in;
   logic                rb_oe;
   logic                ready_busy_n;
   int                  num_errors   = 0;
   int                  total_checks = 0;

   assign ready_busy_n = rb_oe ? 1'h0 : 1'h1;

   fws_host_ctrl i_fws_host_ctrl (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .flash_busy(flash_busy),
      .flash_pins(flash_pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
   fws_flash_model i_fws_flash_model (.pins(flash_pins), .dq_in(dq_in), .rb_oe(rb_oe));

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ==========================================================
   // Checks and verdict
   task automatic fail(input string msg);
      num_errors++;
      $display("FAIL at %0t: %s", $time, msg);
   endtask : fail

   task automatic cmp_code(input fws_pkg::fws_res_t exp, input string msg);
      total_checks++;
      if (rsp.code !== exp)
         fail(msg);
   endtask : cmp_code

   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp)
         fail(msg);
   endtask : cmp_bit

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
         fail(msg);
   endtask : cmp_byte

   task automatic print_verdict;
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // User request with bounded wait for the response pulse
   task automatic do_req(input fws_pkg::fws_op_t op, input logic [21:0] a);
      int n;
      n = 0;
      @(posedge clk);
      #2;
      req_valid = 1'h1;
      req = '{op: op, addr: a};
      @(posedge clk);
      #2;
      req_valid = 1'h0;
      while (rsp_valid !== 1'h1 && n < 2000) begin
         @(posedge clk);
         #2;
         n++;
      end
      if (n == 2000)
         fail("no response");
   endtask : do_req

   task automatic settle;
      repeat (4) @(posedge clk);
      #2;
   endtask : settle

   // ==========================================================
   // Tests
   initial begin
      repeat (4) @(posedge clk);
      #2;
      sys_rst = 1'h0;
      cmp_bit(req_ready, 1'h1, "not ready after reset");
      cmp_bit(flash_pins === fws_pkg::PINS_IDLE, 1'h1, "pins not idle");
      i_fws_flash_model.start(0, 1'h0, 1'h0, 1'h0);
      do_req(fws_pkg::OP_POLL, 22'h010000);
      cmp_code(fws_pkg::RES_DONE, "idle poll");
      cmp_bit(rsp.status[fws_pkg::BIT_POLL], 1'h1, "poll bit idle");
      i_fws_flash_model.start(3, 1'h0, 1'h0, 1'h0);
      settle();
      cmp_bit(flash_busy, 1'h1, "busy not seen");
      cmp_bit(rsp.busy_pin, 1'h1, "busy pin not seen");
      do_req(fws_pkg::OP_POLL, 22'h010000);
      cmp_code(fws_pkg::RES_DONE, "toggling poll");
      settle();
      cmp_bit(flash_busy, 1'h0, "ready not seen");
      cmp_bit(rsp.busy_pin, 1'h0, "ready pin not seen");
      i_fws_flash_model.start(2, 1'h1, 1'h0, 1'h0);
      do_req(fws_pkg::OP_POLL, 22'h020000);
      cmp_code(fws_pkg::RES_DONE, "late stop with limit flag");
      cmp_byte(8'(i_fws_flash_model.writes), 8'h00, "stray write");
      i_fws_flash_model.start(1000, 1'h1, 1'h0, 1'h0);
      do_req(fws_pkg::OP_POLL, 22'h020000);
      cmp_code(fws_pkg::RES_FAIL, "limit failure");
      cmp_bit(rsp.status[fws_pkg::BIT_TIMEOUT], 1'h1, "limit bit");
      cmp_bit(rsp.status[fws_pkg::BIT_POLL], 1'h0, "poll bit busy");
      cmp_byte(i_fws_flash_model.cmd, fws_pkg::CMD_RESET, "no reset cmd");
      cmp_bit(i_fws_flash_model.cmd_addr === fws_pkg::RESET_ADDR, 1'h1, "reset addr");
      i_fws_flash_model.start(1000, 1'h0, 1'h0, 1'h0);
      do_req(fws_pkg::OP_SUSPEND, 22'h030000);
      cmp_code(fws_pkg::RES_DONE, "suspend");
      cmp_byte(i_fws_flash_model.cmd, fws_pkg::CMD_SUSPEND, "no suspend cmd");
      settle();
      cmp_bit(flash_busy, 1'h0, "busy in suspend");
      do_req(fws_pkg::OP_POLL, 22'h030000);
      cmp_code(fws_pkg::RES_DONE, "poll in suspend");
      do_req(fws_pkg::OP_RESET, 22'h000000);
      cmp_code(fws_pkg::RES_DONE, "reset op");
      cmp_byte(i_fws_flash_model.cmd, fws_pkg::CMD_RESET, "reset cmd");
      i_fws_flash_model.start(0, 1'h0, 1'h0, 1'h0);
      do_req(fws_pkg::OP_ADD_SECTOR, 22'h048000);
      cmp_code(fws_pkg::RES_DONE, "add in open window");
      cmp_byte(8'(i_fws_flash_model.adds), 8'h01, "add count");
      cmp_bit(i_fws_flash_model.cmd_addr === 22'h048000, 1'h1, "sector addr");
      i_fws_flash_model.start(0, 1'h0, 1'h0, 1'h1);
      do_req(fws_pkg::OP_ADD_SECTOR, 22'h050000);
      cmp_code(fws_pkg::RES_UNSURE, "window closed after add");
      do_req(fws_pkg::OP_ADD_SECTOR, 22'h058000);
      cmp_code(fws_pkg::RES_REFUSED, "add in closed window");
      cmp_bit(rsp.status[fws_pkg::BIT_WINDOW], 1'h1, "window bit");
      cmp_byte(8'(i_fws_flash_model.adds), 8'h02, "write in closed window");
      cmp_byte(8'(i_fws_flash_model.writes), 8'h05, "strobe in closed window");
      print_verdict();
   end

   initial begin
      #(25 * 40000);
      fail("watchdog");
      print_verdict();
   end
endmodule : test_fws_host_ctrl
